// ===== inc/counter_ctl_pkg.sv
// constants shared by the counter, handshake and interrupt control logic
package counter_ctl_pkg;

  // ****************************************
  // host word port
  // ****************************************
  localparam int           ADDR_W       = 5;
  localparam int           DATA_W       = 16;
  localparam logic [4:0]   CTRL_OFS     = 5'h12;
  localparam logic [4:0]   PBC_OFS      = 5'h14;
  localparam logic [4:0]   LOAD1_OFS    = 5'h16;
  localparam logic [4:0]   LOAD2_OFS    = 5'h18;
  localparam logic [4:0]   LOAD3_OFS    = 5'h1A;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int           CTRL_W                             = 10;
  localparam int           GROUP_ONE_TC_IRQ_ENABLE_BIT        = 0;
  localparam int           GROUP_TWO_TC_IRQ_ENABLE_BIT        = 1;
  localparam int           FIRST_COUNTER_ENABLE_BIT           = 2;
  localparam int           SECOND_COUNTER_ENABLE_BIT          = 3;
  localparam int           GROUP_ONE_COUNTER_HANDSHAKE_EN_BIT = 4;
  localparam int           GROUP_TWO_COUNTER_HANDSHAKE_EN_BIT = 5;
  localparam int           THIRD_COUNTER_IRQ_ENABLE_BIT       = 6;
  localparam int           FIRST_COUNTER_SOURCE_SELECT_BIT    = 8;
  localparam int           SECOND_COUNTER_SOURCE_SELECT_BIT   = 9;
  localparam logic [9:0]   CTRL_RESET                         = 10'h000;

  // ****************************************
  // pulse, buffer and compatibility word
  // ****************************************
  localparam int           PBC_W        = 4;
  localparam int           REV_COMPAT_BIT        = 0;
  localparam int           PORT_D_DBLBUF_BIT     = 1;
  localparam int           GROUP_ONE_LPULSE_BIT  = 2;
  localparam int           GROUP_TWO_LPULSE_BIT  = 3;
  localparam logic [3:0]   PBC_RESET    = 4'h0;
  localparam int           REV_C        = 3;

  // ****************************************
  // counters and timebase
  // ****************************************
  localparam int           NUM_COUNTERS = 3;
  localparam logic [15:0]  LOAD_RESET   = 16'hFFFF;
  localparam int           CLK_HZ       = 250_000_000;
  localparam int           SRC_HZ       = 10_000_000;
  localparam int           TICK_DIV     = CLK_HZ / SRC_HZ;
  localparam int           DIV_W        = $clog2(TICK_DIV);

endpackage

// ===== inc/count_if.sv
// link between the control logic and one gated counter
`timescale 1ns/1ps
interface count_if #(parameter int width = 16) ();
  logic             tick;
  logic             run;
  logic [width-1:0] reload;
  logic             out;

  modport ctrl    (output tick, output run, output reload, input out);
  modport counter (input tick, input run, input reload, output out);
endinterface

// ===== hw/gated_counter.sv
// reloading down counter with gate and square-wave output
`timescale 1ns/1ps
module gated_counter #(
  parameter int width = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  count_if.counter cnt
);
  import counter_ctl_pkg::*;

  typedef struct packed {
    logic [width-1:0] count;
    logic             out;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  // ****************************************
  // count on source ticks while running
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (cnt.tick && cnt.run) begin
      if (s_q.count == '0) begin
        s_d.count = cnt.reload;
        s_d.out   = ~s_q.out;
      end else begin
        s_d.count = s_q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt.out = s_q.out;
endmodule

// ===== hw/rise_pulse.sv
// one-cycle pulse on each rising edge of a level
`timescale 1ns/1ps
module rise_pulse (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      pulse
);
  import counter_ctl_pkg::*;

  typedef struct packed {
    logic prev;
    logic pulse;
  } edge_state_t;

  edge_state_t s_q;
  edge_state_t s_d;

  // ****************************************
  // compare successive samples
  // ****************************************
  always_comb begin
    s_d       = s_q;
    s_d.pulse = level & ~s_q.prev;
    s_d.prev  = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;
endmodule

// ===== hw/counter_handshake_irq_control.sv
// counter gating, handshake request routing and interrupt request control
`timescale 1ns/1ps
module counter_handshake_irq_control #(
  parameter int cnt_width = 16,
  parameter int revision  = counter_ctl_pkg::REV_C
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic [counter_ctl_pkg::ADDR_W-1:0]  host_addr,
  input  wire logic                                host_wr,
  input  wire logic                                host_word,
  input  wire logic [counter_ctl_pkg::DATA_W-1:0]  host_wdata,
  input  wire logic                                external_gate_input,
  input  wire logic                                ext_req_group_one,
  input  wire logic                                ext_req_group_two,
  input  wire logic                                dma_tc_group_one,
  input  wire logic                                dma_tc_group_two,
  output logic                                     req_group_one_q,
  output logic                                     req_group_two_q,
  output logic                                     irq_group_one_q,
  output logic                                     irq_group_two_q,
  output logic [counter_ctl_pkg::NUM_COUNTERS-1:0] counter_out_q,
  output logic [counter_ctl_pkg::CTRL_W-1:0]       control_q,
  output logic [counter_ctl_pkg::PBC_W-1:0]        pulse_buffer_compat_config_q
);
  import counter_ctl_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [CTRL_W-1:0]                      ctrl;
    logic [PBC_W-1:0]                       pbc;
    logic [NUM_COUNTERS-1:0][cnt_width-1:0] reload;
    logic [DIV_W-1:0]                       div;
    logic                                   tick;
    logic                                   req_one;
    logic                                   req_two;
    logic                                   irq_one;
    logic                                   irq_two;
    logic [NUM_COUNTERS-1:0]                cnt_out;
  } ctl_state_t;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam bit               HAS_PBC  = (revision >= REV_C);

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic [NUM_COUNTERS-1:0] cnt_out;
  logic                    cnt3_rise;
  logic                    tc_one_rise;
  logic                    tc_two_rise;
  logic                    word_wr;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign word_wr = host_wr & host_word;

  // ****************************************
  // counters
  // ****************************************
  count_if #(.width(cnt_width)) cif[NUM_COUNTERS] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      gated_counter #(
        .width (cnt_width)
      ) u_cnt (
        .clk   (clk),
        .rst_n (rst_n),
        .cnt   (cif[gi])
      );
      assign cif[gi].reload = s_q.reload[gi];
      assign cnt_out[gi]    = cif[gi].out;
    end
  endgenerate

  assign cif[0].tick = s_q.ctrl[FIRST_COUNTER_SOURCE_SELECT_BIT]  ? cnt3_rise : s_q.tick;
  assign cif[1].tick = s_q.ctrl[SECOND_COUNTER_SOURCE_SELECT_BIT] ? cnt3_rise : s_q.tick;
  assign cif[2].tick = s_q.tick;

  assign cif[0].run = s_q.ctrl[FIRST_COUNTER_ENABLE_BIT] & external_gate_input;
  assign cif[1].run = s_q.ctrl[SECOND_COUNTER_ENABLE_BIT] & external_gate_input;
  assign cif[2].run = 1'b1;

  // ****************************************
  // edge detectors
  // ****************************************
  // third counter edge
  rise_pulse u_cnt3_rise (
    .clk   (clk),
    .rst_n (rst_n),
    .level (cnt_out[2]),
    .pulse (cnt3_rise)
  );

  rise_pulse u_tc_one_rise (
    .clk   (clk),
    .rst_n (rst_n),
    .level (dma_tc_group_one),
    .pulse (tc_one_rise)
  );

  rise_pulse u_tc_two_rise (
    .clk   (clk),
    .rst_n (rst_n),
    .level (dma_tc_group_two),
    .pulse (tc_two_rise)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;

    // 10 mhz source tick
    if (s_q.div == DIV_LAST) begin
      s_d.div  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div  = s_q.div + 1'b1;
      s_d.tick = 1'b0;
    end

    // host writes
    if (word_wr) begin
      if (hit(host_addr, CTRL_OFS)) begin
        s_d.ctrl = host_wdata[CTRL_W-1:0];
      end
      if (HAS_PBC && hit(host_addr, PBC_OFS)) begin
        s_d.pbc = host_wdata[PBC_W-1:0];
      end
      if (hit(host_addr, LOAD1_OFS)) begin
        s_d.reload[0] = host_wdata[cnt_width-1:0];
      end
      if (hit(host_addr, LOAD2_OFS)) begin
        s_d.reload[1] = host_wdata[cnt_width-1:0];
      end
      if (hit(host_addr, LOAD3_OFS)) begin
        s_d.reload[2] = host_wdata[cnt_width-1:0];
      end
    end

    s_d.req_one = s_q.ctrl[GROUP_ONE_COUNTER_HANDSHAKE_EN_BIT] ? cnt_out[0] : ext_req_group_one;
    s_d.req_two = s_q.ctrl[GROUP_TWO_COUNTER_HANDSHAKE_EN_BIT] ? cnt_out[1] : ext_req_group_two;

    s_d.irq_one = s_q.ctrl[GROUP_ONE_TC_IRQ_ENABLE_BIT] & tc_one_rise;
    s_d.irq_two = (s_q.ctrl[GROUP_TWO_TC_IRQ_ENABLE_BIT] & tc_two_rise)
                | (s_q.ctrl[THIRD_COUNTER_IRQ_ENABLE_BIT] & cnt3_rise);

    s_d.cnt_out = cnt_out;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.ctrl    <= CTRL_RESET;
      s_q.pbc     <= PBC_RESET;
      s_q.reload  <= {NUM_COUNTERS{LOAD_RESET[cnt_width-1:0]}};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign req_group_one_q              = s_q.req_one;
  assign req_group_two_q              = s_q.req_two;
  assign irq_group_one_q              = s_q.irq_one;
  assign irq_group_two_q              = s_q.irq_two;
  assign counter_out_q                = s_q.cnt_out;
  assign control_q                    = s_q.ctrl;
  assign pulse_buffer_compat_config_q = s_q.pbc;
endmodule

// ===== bench/chk_props.sv
// port assertions for the counter, handshake and interrupt control block
`timescale 1ns/1ps
module chk_props #(
  parameter int revision = counter_ctl_pkg::REV_C
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  host_addr,
  input wire logic        host_wr,
  input wire logic        host_word,
  input wire logic [15:0] host_wdata,
  input wire logic        external_gate_input,
  input wire logic        ext_req_group_one,
  input wire logic        dma_tc_group_one,
  input wire logic        dma_tc_group_two,
  input wire logic        req_group_one_q,
  input wire logic        irq_group_one_q,
  input wire logic        irq_group_two_q,
  input wire logic [2:0]  counter_out_q,
  input wire logic [9:0]  control_q,
  input wire logic [3:0]  pulse_buffer_compat_config_q
);
  import counter_ctl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_tc1; $rose(dma_tc_group_one) ##1 control_q[0]; endsequence
  sequence s_tc2; $rose(dma_tc_group_two) ##1 control_q[1]; endsequence
  sequence s_wr; host_wr && host_word; endsequence
  property p_tc1; s_tc1 |-> ##1 irq_group_one_q; endproperty
  property p_tc2; s_tc2 |-> ##1 irq_group_two_q; endproperty
  property p_quiet1; !control_q[0] [*3] |-> !irq_group_one_q; endproperty
  property p_quiet2; (!control_q[1] && !control_q[6]) [*3] |-> !irq_group_two_q; endproperty
  property p_cnt3; $rose(counter_out_q[2]) && control_q[6] |-> ##[0:2] irq_group_two_q; endproperty
  property p_hs1; $past(control_q[4]) |-> req_group_one_q == counter_out_q[0]; endproperty
  property p_ext1;
    $past(rst_n) && !$past(control_q[4]) |-> req_group_one_q == $past(ext_req_group_one);
  endproperty
  property p_gate1; (!control_q[2] || !external_gate_input) [*5] |-> $stable(counter_out_q[0]); endproperty
  property p_ctl; s_wr ##0 host_addr == CTRL_OFS |=> control_q == $past(host_wdata[9:0]); endproperty
  property p_cfg;
    s_wr ##0 (revision >= REV_C && host_addr == PBC_OFS) |=>
      pulse_buffer_compat_config_q == $past(host_wdata[3:0]);
  endproperty
  property p_half; host_wr && !host_word |=> $stable(pulse_buffer_compat_config_q); endproperty
  a_tc1: assert property (p_tc1) else $error("group one tc irq missing");
  a_tc2: assert property (p_tc2) else $error("group two tc irq missing");
  a_quiet1: assert property (p_quiet1) else $error("group one irq while disabled");
  a_quiet2: assert property (p_quiet2) else $error("group two irq while disabled");
  a_cnt3: assert property (p_cnt3) else $error("counter three irq missing");
  a_hs1: assert property (p_hs1) else $error("group one request not from counter one");
  a_ext1: assert property (p_ext1) else $error("group one request not from input");
  a_gate1: assert property (p_gate1) else $error("counter one moved while gated");
  a_ctl: assert property (p_ctl) else $error("control word not stored");
  a_cfg: assert property (p_cfg) else $error("config word not stored");
  a_half: assert property (p_half) else $error("byte write changed config");
endmodule

// ===== bench/host_model.sv
// host side: word and byte writes and dma terminal count lines
`timescale 1ns/1ps
module host_model (
  input wire logic                               clk,
  output logic [counter_ctl_pkg::ADDR_W-1:0]     host_addr,
  output logic                                   host_wr,
  output logic                                   host_word,
  output logic [counter_ctl_pkg::DATA_W-1:0]     host_wdata,
  output logic                                   dma_tc_group_one,
  output logic                                   dma_tc_group_two
);
  import counter_ctl_pkg::*;
  initial begin
    {host_addr, host_wr, host_word, host_wdata} = '0;
    {dma_tc_group_one, dma_tc_group_two} = 2'b00;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_word <= w;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask
  task automatic tc(input logic g);
    @(posedge clk);
    if (g) dma_tc_group_two <= 1'b1;
    else dma_tc_group_one <= 1'b1;
    repeat (2) @(posedge clk);
    {dma_tc_group_one, dma_tc_group_two} <= 2'b00;
  endtask
endmodule

// ===== bench/counter_handshake_irq_control_test.sv
// self-checking bench for the counter, handshake and interrupt control
`timescale 1ns/1ps
`define chk(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
bind counter_handshake_irq_control chk_props #(.revision(revision)) u_chk (.*);
module counter_handshake_irq_control_test;
  import counter_ctl_pkg::*;
  typedef struct {logic [9:0] ctl; logic e1, e2, grp, i1, i2, r1, r2;} row_t;
  row_t rows[7] = '{'{10'h001, 1, 0, 0, 1, 0, 1, 0}, '{10'h000, 0, 1, 0, 0, 0, 0, 1},
                    '{10'h002, 0, 0, 1, 0, 1, 0, 0}, '{10'h001, 0, 0, 1, 0, 0, 0, 0},
                    '{10'h010, 1, 1, 0, 0, 0, 0, 1}, '{10'h020, 1, 1, 1, 0, 0, 1, 0},
                    '{10'h003, 0, 0, 0, 1, 0, 0, 0}};
  logic        clk, rst_n, external_gate_input, ext_req_group_one, ext_req_group_two;
  logic [4:0]  host_addr;
  logic        host_wr, host_word, dma_tc_group_one, dma_tc_group_two;
  logic [15:0] host_wdata;
  logic        req_group_one_q, req_group_two_q, irq_group_one_q, irq_group_two_q;
  logic [2:0]  counter_out_q;
  logic [9:0]  control_q;
  logic [3:0]  pulse_buffer_compat_config_q;
  int          n_errors, n_tests, c1, c2, c3, ci;
  counter_handshake_irq_control #(.cnt_width(16), .revision(REV_C)) dut (.*);
  host_model p (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic complete_run();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic watch(input int n);
    logic [2:0] pv;
    {c1, c2, c3, ci} = '0;
    #1 pv = counter_out_q;
    repeat (n) begin
      @(posedge clk);
      #1;
      c1 += int'(counter_out_q[0] && !pv[0]);
      c2 += int'(counter_out_q[1] && !pv[1]);
      c3 += int'(counter_out_q[2] && !pv[2]);
      ci += int'(irq_group_two_q);
      pv = counter_out_q;
    end
  endtask
  task automatic run_ctl(input logic [9:0] c, input logic g);
    external_gate_input <= g;
    p.wr(CTRL_OFS, {6'h00, c}, 1'b1);
    watch(500);
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    {rst_n, external_gate_input, ext_req_group_one, ext_req_group_two} = 4'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `chk({control_q, pulse_buffer_compat_config_q, irq_group_one_q, irq_group_two_q}, 16'h0000)
    p.wr(LOAD3_OFS, 16'h0001, 1'b1);
    p.wr(LOAD1_OFS, 16'h0001, 1'b1);
    p.wr(LOAD2_OFS, 16'h0001, 1'b1);
    foreach (rows[k]) begin
      p.wr(CTRL_OFS, {6'h00, rows[k].ctl}, 1'b1);
      ext_req_group_one <= rows[k].e1;
      ext_req_group_two <= rows[k].e2;
      p.tc(rows[k].grp);
      #1;
      `chk(control_q, rows[k].ctl)
      `chk(irq_group_one_q, rows[k].i1)
      `chk(irq_group_two_q, rows[k].i2)
      `chk(req_group_one_q, rows[k].r1)
      `chk(req_group_two_q, rows[k].r2)
    end
    run_ctl(10'h04C, 1'b1);
    watch(1000);
    `chk(c1, 10)
    `chk(c2, 10)
    `chk(ci, 10)
    `chk(c3, ci)
    run_ctl(10'h00C, 1'b0);
    watch(1000);
    `chk(c1 + c2, 0)
    `chk({c3, ci}, {32'd10, 32'd0})
    run_ctl(10'h104, 1'b1);
    watch(1200);
    `chk(c1, 3)
    p.wr(PBC_OFS, 16'h000A, 1'b1);
    p.wr(PBC_OFS, 16'h0005, 1'b0);
    p.wr(5'h1E, 16'h03FF, 1'b1);
    @(posedge clk);
    #1;
    `chk(pulse_buffer_compat_config_q, 4'hA)
    `chk(control_q, 10'h104)
    complete_run();
  end
endmodule
